/* rtl/umlc_pkg.sv */
// Purpose: constants and types for the Manchester and LIN configuration slice
// Assumes: byte addressed plain register port, 32-bit data
// Notes:   offsets, Manchester field positions and the Manchester, LIN mode and identifier reset values live here
package umlc_pkg;

    // ****************************************************************
    // Register offsets
    // ****************************************************************
    localparam logic [7:0] UMLC_OFF_MODE     = 8'h04;
    localparam logic [7:0] UMLC_OFF_BAUD     = 8'h20;
    localparam logic [7:0] UMLC_OFF_RXTO     = 8'h24;
    localparam logic [7:0] UMLC_OFF_GUARD    = 8'h28;
    localparam logic [7:0] UMLC_OFF_RATIO    = 8'h40;
    localparam logic [7:0] UMLC_OFF_FILTER   = 8'h4c;
    localparam logic [7:0] UMLC_OFF_MAN      = 8'h50;
    localparam logic [7:0] UMLC_OFF_LINMODE  = 8'h54;
    localparam logic [7:0] UMLC_OFF_LINID    = 8'h58;
    localparam logic [7:0] UMLC_OFF_LINBAUD  = 8'h5c;
    localparam logic [7:0] UMLC_OFF_PMODE    = 8'he4;
    localparam logic [7:0] UMLC_OFF_PSTAT    = 8'he8;
    localparam logic [7:0] UMLC_OFF_REV      = 8'hfc;

    // ****************************************************************
    // Reset values, masks and keys
    // ****************************************************************
    localparam logic [31:0] UMLC_MAN_RESET   = 32'h3001_1004;
    localparam logic [31:0] UMLC_MAN_MASK    = 32'h530f_130f;
    localparam logic [17:0] UMLC_LINM_RESET  = 18'h0_0000;
    localparam logic [7:0]  UMLC_ID_RESET    = 8'h00;
    localparam logic [23:0] UMLC_KEY         = 24'h55_5341;
    localparam logic [11:0] UMLC_REV_VALUE   = 12'h100; // Arbitrary value

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int UMLC_MAN_DRIFT   = 30;
    localparam int UMLC_MAN_RXPOL   = 28;
    localparam int UMLC_MAN_RXPP    = 24;
    localparam int UMLC_MAN_RXPL    = 16;
    localparam int UMLC_MAN_TXPOL   = 12;
    localparam int UMLC_MAN_TXPP    = 8;
    localparam int UMLC_MAN_TXPL    = 0;
    localparam int UMLC_LM_DMA      = 16;
    localparam int UMLC_KEY_POS     = 8;

    // Preamble kinds
    typedef enum logic [1:0] {
        UMLC_PRE_ONES = 2'b00,
        UMLC_PRE_ZERO = 2'b01,
        UMLC_PRE_ZO   = 2'b10,
        UMLC_PRE_OZ   = 2'b11
    } umlc_pre_t;

    // Node action codes
    typedef enum logic [1:0] {
        UMLC_ACT_SEND = 2'b00,
        UMLC_ACT_RECV = 2'b01,
        UMLC_ACT_NONE = 2'b10,
        UMLC_ACT_RSVD = 2'b11
    } umlc_act_t;

    // Decoded LIN settings for the core
    typedef struct packed {
        logic       resync_en;
        logic       slot_mode_en;
        logic       checksum_en;
        logic       checksum_classic;
        logic       parity_en;
        logic       resp_send;
        logic       resp_recv;
        logic [8:0] resp_len;
        logic [7:0] frame_id_char;
    } umlc_lin_cfg_t;

endpackage

/* rtl/umlc_regs.sv */
// Purpose: Manchester and LIN configuration, write protection, revision
// Assumes: all inputs come from logic on clk_i; one strobe per cycle
// Notes:   derived outputs except ext_wr_ok_o are registered, one cycle behind the registers
`timescale 1ns/1ps
`default_nettype none

module umlc_regs
    import umlc_pkg::*;
(
    // Clock and reset
    input  wire logic                clk_i,
    input  wire logic                reset_i,
    // Register port
    input  wire logic [7:0]          addr_i,
    input  wire logic [31:0]         wdata_i,
    input  wire logic                wr_i,
    input  wire logic                rd_i,
    output logic [31:0]              rdata_o,
    // Write grant for protected registers held elsewhere
    output logic                     ext_wr_ok_o,
    // Core status
    input  wire logic                lin_master_i,
    input  wire logic                over16_i,
    input  wire logic                id_rx_vld_i,
    input  wire logic [7:0]          id_rx_char_i,
    input  wire logic                sync_done_i,
    input  wire logic [15:0]         sync_div_i,
    input  wire logic [2:0]          sync_frac_i,
    // DMA path into the node mode register
    input  wire logic                dma_wr_i,
    input  wire logic [31:0]         dma_data_i,
    // Wake request from the control register
    input  wire logic                send_wake_cmd_i,
    output logic                     wake_lin20_o,
    output logic                     wake_lin13_o,
    // Manchester coding helpers
    input  wire logic                tx_bit_i,
    input  wire logic                rx_half_i,
    input  wire logic [3:0]          tx_pre_idx_i,
    input  wire logic [3:0]          rx_pre_idx_i,
    output logic                     tx_half_o,
    output logic                     rx_bit_o,
    output logic                     tx_pre_on_o,
    output logic                     tx_pre_bit_o,
    output logic                     rx_pre_on_o,
    output logic                     rx_pre_bit_o,
    output logic                     drift_on_o,
    // Decoded LIN settings
    output umlc_lin_cfg_t            lin_cfg_o
);

    // ****************************************************************
    // Storage
    // ****************************************************************
    logic [31:0] man_ff;
    logic [17:0] linmode_ff;
    logic [7:0]  frame_id_char_ff;
    logic [15:0] synced_divider_ff;
    logic [2:0]  synced_frac_part_ff;
    logic        protect_on_ff;
    logic        violation_flag_ff;
    logic [15:0] violation_source_ff;
    logic [31:0] rdata_ff;

    // Field views
    logic        drift;
    logic        rx_code_polarity;
    logic        tx_code_polarity;
    umlc_pre_t   rx_preamble_kind;
    umlc_pre_t   tx_preamble_kind;
    logic [3:0]  rx_preamble_len;
    logic [3:0]  tx_preamble_len;
    logic        slave_resync_off;
    logic        dma_loads_linmode;
    logic [7:0]  resp_len_count;
    logic        wake_signal_kind;
    logic        slot_mode_off;
    logic        resp_len_source;
    logic        checksum_kind;
    logic        checksum_off;
    logic        id_parity_off;
    umlc_act_t   node_action;

    // Access decode
    logic        is_protected;
    logic        blocked;
    logic        key_ok;
    logic [31:0] nxt_rdata;
    logic [8:0]  nxt_resp_len;

    // ****************************************************************
    // Field extraction
    // ****************************************************************
    assign drift             = man_ff[UMLC_MAN_DRIFT];
    assign rx_code_polarity  = man_ff[UMLC_MAN_RXPOL];
    assign tx_code_polarity  = man_ff[UMLC_MAN_TXPOL];
    assign rx_preamble_kind  = umlc_pre_t'(man_ff[UMLC_MAN_RXPP +: 2]);
    assign tx_preamble_kind  = umlc_pre_t'(man_ff[UMLC_MAN_TXPP +: 2]);
    assign rx_preamble_len   = man_ff[UMLC_MAN_RXPL +: 4];
    assign tx_preamble_len   = man_ff[UMLC_MAN_TXPL +: 4];
    assign slave_resync_off  = linmode_ff[17];
    assign dma_loads_linmode = linmode_ff[UMLC_LM_DMA];
    assign resp_len_count    = linmode_ff[15:8];
    assign wake_signal_kind  = linmode_ff[7];
    assign slot_mode_off     = linmode_ff[6];
    assign resp_len_source   = linmode_ff[5];
    assign checksum_kind     = linmode_ff[4];
    assign checksum_off      = linmode_ff[3];
    assign id_parity_off     = linmode_ff[2];
    assign node_action       = umlc_act_t'(linmode_ff[1:0]);

    // ****************************************************************
    // Write protection decode
    // ****************************************************************
    // Offsets covered by the protection enable
    always_comb begin
        case (addr_i)
            UMLC_OFF_MODE,
            UMLC_OFF_BAUD,
            UMLC_OFF_RXTO,
            UMLC_OFF_GUARD,
            UMLC_OFF_RATIO,
            UMLC_OFF_FILTER,
            UMLC_OFF_MAN:    is_protected = 1'b1;
            default:         is_protected = 1'b0;
        endcase
    end

    assign blocked     = wr_i && is_protected && protect_on_ff;
    // Registers outside this slice store only on this grant
    assign ext_wr_ok_o = wr_i && is_protected && !protect_on_ff
                         && (addr_i != UMLC_OFF_MAN);
    assign key_ok      = wdata_i[31:UMLC_KEY_POS] == UMLC_KEY;

    // ****************************************************************
    // Manchester configuration
    // ****************************************************************
    // Reserved bits keep their reset level
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            man_ff <= UMLC_MAN_RESET;
        end else if (wr_i && addr_i == UMLC_OFF_MAN && !protect_on_ff) begin
            man_ff <= (wdata_i & UMLC_MAN_MASK) | (UMLC_MAN_RESET & ~UMLC_MAN_MASK);
        end
    end

    // ****************************************************************
    // LIN node mode
    // ****************************************************************
    // DMA word wins over a software write in the same cycle
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            linmode_ff <= UMLC_LINM_RESET;
        end else if (dma_wr_i && dma_loads_linmode) begin
            linmode_ff <= {dma_data_i[17], dma_loads_linmode, dma_data_i[15:0]};
        end else if (wr_i && addr_i == UMLC_OFF_LINMODE) begin
            linmode_ff <= wdata_i[17:0];
        end
    end

    // ****************************************************************
    // LIN identifier
    // ****************************************************************
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            frame_id_char_ff <= UMLC_ID_RESET;
        end else if (lin_master_i) begin
            if (wr_i && addr_i == UMLC_OFF_LINID) begin
                frame_id_char_ff <= wdata_i[7:0];
            end
        end else if (id_rx_vld_i) begin
            frame_id_char_ff <= id_rx_char_i;
        end
    end

    // ****************************************************************
    // Synchronized baud divider
    // ****************************************************************
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            synced_divider_ff   <= 16'h0000;
            synced_frac_part_ff <= 3'h0;
        end else if (sync_done_i) begin
            synced_divider_ff   <= sync_div_i;
            synced_frac_part_ff <= sync_frac_i;
        end
    end

    // ****************************************************************
    // Protection mode and status
    // ****************************************************************
    // Enable changes only with the key
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            protect_on_ff <= 1'b0;
        end else if (wr_i && addr_i == UMLC_OFF_PMODE && key_ok) begin
            protect_on_ff <= wdata_i[0];
        end
    end

    // Violation capture; a new violation beats any clear
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            violation_flag_ff   <= 1'b0;
            violation_source_ff <= 16'h0000;
        end else if (blocked) begin
            violation_flag_ff   <= 1'b1;
            violation_source_ff <= {8'h00, addr_i};
        end else if (rd_i && addr_i == UMLC_OFF_PSTAT) begin
            violation_flag_ff   <= 1'b0;
            violation_source_ff <= 16'h0000;
        end else if (wr_i && addr_i == UMLC_OFF_PMODE && key_ok) begin
            violation_flag_ff   <= 1'b0;
            violation_source_ff <= 16'h0000;
        end
    end

    // ****************************************************************
    // Read path
    // ****************************************************************
    // Unmapped offsets read as zero
    always_comb begin
        nxt_rdata = 32'h0000_0000;
        case (addr_i)
            UMLC_OFF_MAN:     nxt_rdata = man_ff;
            UMLC_OFF_LINMODE: nxt_rdata = {14'h0000, linmode_ff};
            UMLC_OFF_LINID:   nxt_rdata = {24'h00_0000, frame_id_char_ff};
            UMLC_OFF_LINBAUD: nxt_rdata = {13'h0000, synced_frac_part_ff,
                                           synced_divider_ff};
            UMLC_OFF_PMODE:   nxt_rdata = {31'h0000_0000, protect_on_ff};
            UMLC_OFF_PSTAT:   nxt_rdata = {8'h00, violation_source_ff,
                                           7'h00, violation_flag_ff};
            UMLC_OFF_REV:     nxt_rdata = {20'h0_0000, UMLC_REV_VALUE};
            default:          nxt_rdata = 32'h0000_0000;
        endcase
    end

    // Read data stand only in the cycle after the strobe
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rdata_ff <= 32'h0000_0000;
        end else if (rd_i) begin
            rdata_ff <= nxt_rdata;
        end else begin
            rdata_ff <= 32'h0000_0000;
        end
    end

    assign rdata_o = rdata_ff;

    // ****************************************************************
    // Response length
    // ****************************************************************
    always_comb begin
        nxt_resp_len = 9'h000;
        if (resp_len_source) begin
            case (frame_id_char_ff[5:4])
                2'b00:   nxt_resp_len = 9'h002;
                2'b01:   nxt_resp_len = 9'h002;
                2'b10:   nxt_resp_len = 9'h004;
                2'b11:   nxt_resp_len = 9'h008;
                default: nxt_resp_len = 9'h002;
            endcase
        end else begin
            nxt_resp_len = {1'b0, resp_len_count} + 9'h001;
        end
    end

    // ****************************************************************
    // Decoded LIN settings
    // ****************************************************************
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            lin_cfg_o <= '0;
        end else begin
            lin_cfg_o.resync_en        <= !slave_resync_off;
            lin_cfg_o.slot_mode_en     <= !slot_mode_off;
            lin_cfg_o.checksum_en      <= !checksum_off;
            lin_cfg_o.checksum_classic <= checksum_kind;
            lin_cfg_o.parity_en        <= !id_parity_off;
            lin_cfg_o.resp_send        <= node_action == UMLC_ACT_SEND;
            lin_cfg_o.resp_recv        <= node_action == UMLC_ACT_RECV;
            lin_cfg_o.resp_len         <= nxt_resp_len;
            lin_cfg_o.frame_id_char    <= frame_id_char_ff;
        end
    end

    // ****************************************************************
    // Wake request
    // ****************************************************************
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            wake_lin20_o <= 1'b0;
            wake_lin13_o <= 1'b0;
        end else begin
            wake_lin20_o <= send_wake_cmd_i && !wake_signal_kind;
            wake_lin13_o <= send_wake_cmd_i && wake_signal_kind;
        end
    end

    // ****************************************************************
    // Manchester coding helpers
    // ****************************************************************
    // Pattern bit for a given preamble position
    function automatic logic pre_bit(input umlc_pre_t kind, input logic [3:0] idx);
        case (kind)
            UMLC_PRE_ONES: pre_bit = 1'b1;
            UMLC_PRE_ZERO: pre_bit = 1'b0;
            UMLC_PRE_ZO:   pre_bit = idx[0];
            UMLC_PRE_OZ:   pre_bit = !idx[0];
            default:       pre_bit = 1'b1;
        endcase
    endfunction

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            tx_half_o    <= 1'b0;
            rx_bit_o     <= 1'b0;
            tx_pre_on_o  <= 1'b0;
            tx_pre_bit_o <= 1'b0;
            rx_pre_on_o  <= 1'b0;
            rx_pre_bit_o <= 1'b0;
            drift_on_o   <= 1'b0;
        end else begin
            tx_half_o    <= tx_bit_i ^ tx_code_polarity;
            rx_bit_o     <= rx_half_i ^ rx_code_polarity;
            tx_pre_on_o  <= tx_pre_idx_i < tx_preamble_len;
            tx_pre_bit_o <= pre_bit(tx_preamble_kind, tx_pre_idx_i);
            rx_pre_on_o  <= rx_pre_idx_i < rx_preamble_len;
            rx_pre_bit_o <= pre_bit(rx_preamble_kind, rx_pre_idx_i);
            drift_on_o   <= drift && over16_i;
        end
    end

endmodule

`default_nettype wire

/* tb/umlc_lin_peer.sv */
// Purpose: remote LIN node and Manchester line partner
// Assumes: commands change just after a rising edge
// Notes:   released lines show their inverse
`timescale 1ns/1ps
`default_nettype none

module umlc_lin_peer
(
    // Clock and commands
    input  wire logic        clk_i,
    input  wire logic        send_id_i,
    input  wire logic        send_sync_i,
    input  wire logic [18:0] val_i,
    input  wire logic        line_bit_i,
    input  wire logic        line_pol_i,
    // Line side
    output logic             id_vld_o,
    output logic [7:0]       id_char_o = 8'h0,
    output logic             sync_done_o,
    output logic [15:0]      sync_div_o = 16'h0,
    output logic [2:0]       sync_frac_o = 3'h0,
    output logic             rx_half_o
);
    // One-cycle results
    always @(posedge clk_i) begin
        id_vld_o <= send_id_i;
        sync_done_o <= send_sync_i;
        id_char_o <= send_id_i ? val_i[7:0] : ~id_char_o;
        {sync_frac_o, sync_div_o} <= send_sync_i ? val_i : ~{sync_frac_o, sync_div_o};
    end
    assign rx_half_o = line_bit_i ^ line_pol_i;
endmodule
`default_nettype wire

/* tb/umlc_properties.sv */
// Purpose: port properties of the slice
// Assumes: single clock, synchronous active high reset
// Notes:   bound to every umlc_regs instance
`timescale 1ns/1ps
`default_nettype none

module umlc_properties
    import umlc_pkg::*;
(
    // Clock, reset, register port
    input wire logic          clk_i,
    input wire logic          reset_i,
    input wire logic [7:0]    addr_i,
    input wire logic [31:0]   wdata_i,
    input wire logic          wr_i,
    input wire logic          rd_i,
    input wire logic [31:0]   rdata_o,
    // Outputs and status
    input wire logic          ext_wr_ok_o,
    input wire logic          over16_i,
    input wire logic          send_wake_cmd_i,
    input wire logic          wake_lin20_o,
    input wire logic          wake_lin13_o,
    input wire logic [3:0]    tx_pre_idx_i,
    input wire logic          tx_pre_on_o,
    input wire logic          drift_on_o,
    input wire umlc_lin_cfg_t lin_cfg_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    // ****************************************************************
    // Sequences and properties
    // ****************************************************************
    sequence s_prot_on;
        wr_i && addr_i == UMLC_OFF_PMODE && wdata_i == {UMLC_KEY, 8'h01};
    endsequence
    sequence s_stat_rd;
        rd_i && addr_i == UMLC_OFF_PSTAT;
    endsequence
    property p_drift; drift_on_o |-> $past(over16_i); endproperty
    a_drift: assert property (p_drift) else $error("drift without 16x");
    property p_tx_pre; tx_pre_on_o |-> $past(tx_pre_idx_i) != 4'hf; endproperty
    a_tx_pre: assert property (p_tx_pre) else $error("preamble too long");
    property p_wake; send_wake_cmd_i |=> wake_lin20_o ^ wake_lin13_o; endproperty
    a_wake: assert property (p_wake) else $error("wake kind wrong");
    property p_no_wake; !send_wake_cmd_i |=> !(wake_lin20_o || wake_lin13_o); endproperty
    a_no_wake: assert property (p_no_wake) else $error("stray wake");
    property p_len;
        !$past(reset_i) |-> lin_cfg_o.resp_len != 9'h0 && lin_cfg_o.resp_len <= 9'h100;
    endproperty
    a_len: assert property (p_len) else $error("bad length");
    property p_act; !(lin_cfg_o.resp_send && lin_cfg_o.resp_recv); endproperty
    a_act: assert property (p_act) else $error("send and receive");
    property p_ok_wr;
        ext_wr_ok_o |-> wr_i && addr_i inside {8'h04, 8'h20, 8'h24, 8'h28, 8'h40, 8'h4c};
    endproperty
    a_ok_wr: assert property (p_ok_wr) else $error("grant without write");
    property p_blk; s_prot_on ##1 wr_i |-> !ext_wr_ok_o; endproperty
    a_blk: assert property (p_blk) else $error("grant while protected");
    property p_viol;
        s_prot_on ##1 (wr_i && addr_i == UMLC_OFF_MAN) ##1 s_stat_rd |=> rdata_o == 32'h5001;
    endproperty
    a_viol: assert property (p_viol) else $error("no violation");
    property p_clr; s_stat_rd ##1 !wr_i ##1 s_stat_rd |=> rdata_o == 32'h0; endproperty
    a_clr: assert property (p_clr) else $error("no clear");
    property p_key0; rd_i && addr_i == UMLC_OFF_PMODE |=> rdata_o[31:8] == 24'h0; endproperty
    a_key0: assert property (p_key0) else $error("key not zero");
endmodule

bind umlc_regs umlc_properties u_props (
    .clk_i, .reset_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .ext_wr_ok_o, .over16_i,
    .send_wake_cmd_i, .wake_lin20_o, .wake_lin13_o, .tx_pre_idx_i, .tx_pre_on_o,
    .drift_on_o, .lin_cfg_o
);
`default_nettype wire

/* tb/umlc_tb.sv */
// Purpose: self-checking bench for the configuration slice
// Assumes: 50 MHz clock, reset held two cycles
// Notes:   seeded random stimulus, corner cases
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fail_count++; \
    $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end

module usart_manchester_lin_config_tb_top
    import umlc_pkg::*;
;
    logic          clk_i = 1'b0;
    logic          reset_i, wr_i, rd_i, lin_master_i, over16_i, dma_wr_i, tx_bit_i;
    logic          send_wake_cmd_i, ext_wr_ok_o, wake_lin20_o, wake_lin13_o, drift_on_o;
    logic          tx_half_o, rx_bit_o, tx_pre_on_o, tx_pre_bit_o, rx_pre_on_o, rx_pre_bit_o;
    logic          id_vld, sync_done, rx_half, send_id, send_sync, line_bit, line_pol;
    logic [2:0]    sync_frac;
    logic [3:0]    tx_pre_idx_i, rx_pre_idx_i;
    logic [7:0]    addr_i, id_char;
    logic [15:0]   sync_div;
    logic [18:0]   pv;
    logic [31:0]   wdata_i, rdata_o, dma_data_i, d, e, r;
    umlc_lin_cfg_t lin_cfg_o, xc;
    int            fail_count, checked;
    logic [7:0]    ta [8] = '{8'h50, 8'h54, 8'h58, 8'h5c, 8'he4, 8'he8, 8'hfc, 8'h10};
    logic [31:0]   tv [8] = '{UMLC_MAN_RESET, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0,
                              {20'h0, UMLC_REV_VALUE}, 32'h0};

    umlc_regs uut (
        .clk_i, .reset_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .ext_wr_ok_o,
        .lin_master_i, .over16_i, .id_rx_vld_i(id_vld), .id_rx_char_i(id_char),
        .sync_done_i(sync_done), .sync_div_i(sync_div), .sync_frac_i(sync_frac),
        .dma_wr_i, .dma_data_i, .send_wake_cmd_i, .wake_lin20_o, .wake_lin13_o,
        .tx_bit_i, .rx_half_i(rx_half), .tx_pre_idx_i, .rx_pre_idx_i, .tx_half_o, .rx_bit_o,
        .tx_pre_on_o, .tx_pre_bit_o, .rx_pre_on_o, .rx_pre_bit_o, .drift_on_o, .lin_cfg_o
    );
    umlc_lin_peer u_peer (
        .clk_i, .send_id_i(send_id), .send_sync_i(send_sync), .val_i(pv),
        .line_bit_i(line_bit), .line_pol_i(line_pol), .id_vld_o(id_vld),
        .id_char_o(id_char), .sync_done_o(sync_done), .sync_div_o(sync_div),
        .sync_frac_o(sync_frac), .rx_half_o(rx_half)
    );

    // Clock and hang guard
    always #10 clk_i = ~clk_i;
    initial begin
        repeat (4000) @(posedge clk_i);
        fail_count++;
        wrap_up();
    end

    // ****************************************************************
    // Bus tasks and expectations
    // ****************************************************************
    task automatic op(input logic w, input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_i);
        wr_i <= w;
        rd_i <= !w;
        addr_i <= a;
        wdata_i <= v;
    endtask
    task automatic idle();
        @(posedge clk_i);
        wr_i <= 1'b0;
        rd_i <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        op(1'b1, a, v);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        op(1'b0, a, 32'h0);
        idle();
        @(negedge clk_i) `CHK(rdata_o, x)
    endtask
    task automatic pulse(input logic s, input logic [31:0] v);
        @(posedge clk_i);
        {send_sync, send_id} <= {s, !s};
        pv <= v[18:0];
        @(posedge clk_i);
        {send_sync, send_id} <= 2'h0;
    endtask
    task automatic dma(input logic [31:0] v);
        @(posedge clk_i);
        dma_wr_i <= 1'b1;
        dma_data_i <= v;
        @(posedge clk_i);
        dma_wr_i <= 1'b0;
    endtask
    function automatic logic pat(input logic [1:0] k, input logic [3:0] i);
        return k[1] ? (i[0] ^ k[0]) : !k[0];
    endfunction
    function automatic logic [8:0] rlen(input logic [31:0] m, input logic [7:0] id);
        if (!m[5]) return {1'b0, m[15:8]} + 9'h1;
        return id[5] ? (id[4] ? 9'h8 : 9'h4) : 9'h2;
    endfunction
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        {wr_i, rd_i, lin_master_i, over16_i, dma_wr_i, send_wake_cmd_i, tx_bit_i} = '0;
        {send_id, send_sync, line_bit, line_pol, addr_i, wdata_i, dma_data_i, pv} = '0;
        {tx_pre_idx_i, rx_pre_idx_i, fail_count, checked} = '0;
        reset_i = 1'b1;
        void'($urandom(32'h417e));
        repeat (2) @(posedge clk_i);
        reset_i <= 1'b0;
        for (int i = 0; i < 8; i++) rd(ta[i], tv[i]);
        // Manchester fields with length corners
        for (int i = 0; i < 24; i++) begin
            d = $urandom;
            if (i < 2) {d[19:16], d[3:0]} = {{4{i[0]}}, {4{!i[0]}}};
            wr(UMLC_OFF_MAN, d);
            {tx_bit_i, line_bit, over16_i, tx_pre_idx_i, rx_pre_idx_i} <= 11'($urandom);
            line_pol <= d[28];
            e = (d & UMLC_MAN_MASK) | (UMLC_MAN_RESET & ~UMLC_MAN_MASK);
            rd(UMLC_OFF_MAN, e);
            `CHK({tx_half_o, rx_bit_o}, {tx_bit_i ^ d[12], line_bit})
            `CHK(drift_on_o, d[30] & over16_i)
            `CHK({tx_pre_on_o, tx_pre_bit_o}, {tx_pre_idx_i < d[3:0], pat(d[9:8], tx_pre_idx_i)})
            `CHK({rx_pre_on_o, rx_pre_bit_o}, {rx_pre_idx_i < d[19:16], pat(d[25:24], rx_pre_idx_i)})
        end
        // LIN settings, all node actions
        for (int i = 0; i < 16; i++) begin
            {d, r} = {$urandom, $urandom};
            d[1:0] = i[1:0];
            d[16] = 1'b0;
            if (i == 4) {d[15:8], d[5]} = 9'h1fe;
            wr(UMLC_OFF_LINID, r);
            lin_master_i <= 1'b1;
            wr(UMLC_OFF_LINMODE, d);
            rd(UMLC_OFF_LINMODE, d & 32'h3_ffff);
            rd(UMLC_OFF_LINID, {24'h0, r[7:0]});
            xc = {~d[17], ~d[6], ~d[3], d[4], ~d[2], d[1:0] == 2'b00, d[1:0] == 2'b01,
                  rlen(d, r[7:0]), r[7:0]};
            `CHK(lin_cfg_o, xc)
            @(posedge clk_i) send_wake_cmd_i <= 1'b1;
            @(posedge clk_i) send_wake_cmd_i <= 1'b0;
            @(negedge clk_i) `CHK({wake_lin20_o, wake_lin13_o}, {~d[7], d[7]})
        end
        // DMA loading on and off
        wr(UMLC_OFF_LINMODE, 32'h1_0000);
        idle();
        d = $urandom;
        dma(d);
        rd(UMLC_OFF_LINMODE, {14'h0, d[17], 1'b1, d[15:0]});
        wr(UMLC_OFF_LINMODE, 32'h0);
        idle();
        dma(d);
        rd(UMLC_OFF_LINMODE, 32'h0);
        // Slave identifier and synced divider
        wr(UMLC_OFF_LINID, ~r);
        lin_master_i <= 1'b0;
        rd(UMLC_OFF_LINID, {24'h0, r[7:0]});
        d = $urandom;
        pulse(1'b0, d);
        rd(UMLC_OFF_LINID, {24'h0, d[7:0]});
        pulse(1'b1, d);
        rd(UMLC_OFF_LINBAUD, {13'h0, d[18:0]});
        // Protection: wrong key, blocks, clears
        wr(UMLC_OFF_PMODE, {24'h12_3456, 8'h01});
        wr(UMLC_OFF_MODE, 32'h1);
        @(negedge clk_i) `CHK(ext_wr_ok_o, 1'b1)
        wr(UMLC_OFF_PMODE, {UMLC_KEY, 8'h01});
        wr(UMLC_OFF_MAN, 32'h0);
        rd(UMLC_OFF_PSTAT, 32'h5001);
        rd(UMLC_OFF_PSTAT, 32'h0);
        rd(UMLC_OFF_MAN, e);
        rd(UMLC_OFF_PMODE, 32'h1);
        wr(UMLC_OFF_MODE, 32'h1);
        @(negedge clk_i) `CHK(ext_wr_ok_o, 1'b0)
        rd(UMLC_OFF_PSTAT, 32'h0401);
        wr(UMLC_OFF_BAUD, 32'h1);
        wr(UMLC_OFF_PMODE, {UMLC_KEY, 8'h00});
        rd(UMLC_OFF_PSTAT, 32'h0);
        wr(UMLC_OFF_MAN, 32'h0);
        rd(UMLC_OFF_MAN, UMLC_MAN_RESET & ~UMLC_MAN_MASK);
        wrap_up();
    end
endmodule
`default_nettype wire
